//--- smcms_monitor.sv
`timescale 1ns/10ps
module smcms_monitor
    import smcms_pkg::*;
(
    // clock and reset
    input wire logic sys_clk,
    input wire logic rstn,
    // register bus
    input wire logic [31:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // clock and stop control
    input wire logic sleep_active,
    input wire smcms_ratio_type clock_ratio,
    input wire logic core_clk_en,
    input wire logic peri_clk_en,
    input wire logic bus_clk_en,
    input wire smcms_gate_type module_gate,
    input wire logic all_clock_stop
);
    default clocking mon_cb @(posedge sys_clk);
    endclocking
    default disable iff (!rstn);

    wire aw_mapped = s_axi_awaddr == ADDR_BOOT_MODE || s_axi_awaddr == ADDR_CLK_DIV
        || s_axi_awaddr == ADDR_GATE_A || s_axi_awaddr == ADDR_GATE_B
        || s_axi_awaddr == ADDR_GATE_C;
    // ram banks stay out: they do not block the deep sleep
    wire all_off = sleep_active && module_gate.a[ALL_STOP_EN_BIT]
        && ((module_gate.a & PERIPH_A) == PERIPH_A) && ((module_gate.b & PERIPH_B) == PERIPH_B)
        && ((module_gate.c & PERIPH_C) == PERIPH_C);

    sequence wr_taken;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready && !s_axi_bvalid;
    endsequence
    sequence wr_answer;
        !s_axi_bvalid && !s_axi_awready ##1 s_axi_bvalid;
    endsequence
    sequence rd_taken;
        s_axi_arvalid && s_axi_arready;
    endsequence

    write_answer_a: assert property (wr_taken |=> wr_answer)
        else $error("write answer late or early");
    unmapped_err_a: assert property ((wr_taken ##0 !aw_mapped) |-> ##2 s_axi_bresp == RESP_SLVERR)
        else $error("unmapped write not refused");
    read_answer_a: assert property (rd_taken |=> s_axi_rvalid && !s_axi_arready)
        else $error("read answer missing");
    read_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped");
    resp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped");
    upper_zero_a: assert property (s_axi_rvalid |-> s_axi_rdata[31:16] == 16'h0000)
        else $error("undefined read bits set");
    core_rate_a: assert property ((rstn && clock_ratio.core == 3'h0) [*2]
        |-> core_clk_en)
        else $error("core enable missing at code 0");
    peri_rate_a: assert property ((clock_ratio.peri == 3'h1) [*8] |-> peri_clk_en != $past(peri_clk_en))
        else $error("peripheral enable not every second cycle");
    bus_rate_a: assert property ((rstn && clock_ratio.bus == 3'h0) [*2]
        |-> bus_clk_en)
        else $error("bus enable missing at code 0");
    sleep_stop_a: assert property (all_off |=> all_clock_stop)
        else $error("deep stop not entered");
    sleep_run_a: assert property (!all_off |=> !all_clock_stop)
        else $error("deep stop without cause");
    gate_hold_a: assert property (!$rose(s_axi_bvalid) |-> $stable(module_gate))
        else $error("gates changed without a write");
endmodule

bind smcms_top smcms_monitor smcms_monitor_inst (
    .sys_clk(sys_clk), .rstn(rstn), .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .sleep_active(sleep_active),
    .clock_ratio(clock_ratio), .core_clk_en(core_clk_en), .peri_clk_en(peri_clk_en),
    .bus_clk_en(bus_clk_en), .module_gate(module_gate), .all_clock_stop(all_clock_stop)
);

//--- smcms_pkg.sv
package smcms_pkg;

    // register indices; byte address is four times the index
    localparam logic [23:0] IDX_BOOT_MODE = 24'hFFFDC0;
    localparam logic [23:0] IDX_CLK_DIV = 24'hFFFDC4;
    localparam logic [23:0] IDX_GATE_A = 24'hFFFDC8;
    localparam logic [23:0] IDX_GATE_B = 24'hFFFDCA;
    localparam logic [23:0] IDX_GATE_C = 24'hFFFDCC;

    localparam logic [31:0] ADDR_BOOT_MODE = {6'h00, IDX_BOOT_MODE, 2'h0};
    localparam logic [31:0] ADDR_CLK_DIV = {6'h00, IDX_CLK_DIV, 2'h0};
    localparam logic [31:0] ADDR_GATE_A = {6'h00, IDX_GATE_A, 2'h0};
    localparam logic [31:0] ADDR_GATE_B = {6'h00, IDX_GATE_B, 2'h0};
    localparam logic [31:0] ADDR_GATE_C = {6'h00, IDX_GATE_C, 2'h0};

    // field positions
    localparam int MODE_TOP_BIT = 15;
    localparam int MODE_SEL_LSB = 8;
    localparam int CORE_LSB = 8;
    localparam int PERI_LSB = 4;
    localparam int BUS_LSB = 0;
    localparam int ALL_STOP_EN_BIT = 15;
    localparam int RATIO_W = 3;
    localparam int DIV_W = 7;

    // writable bits of each register
    localparam logic [15:0] MASK_CLK_DIV = 16'h0777;
    localparam logic [15:0] MASK_GATE_A = 16'hB329;
    localparam logic [15:0] MASK_GATE_B = 16'h97C0;
    localparam logic [15:0] MASK_GATE_C = 16'hFC1F;

    // peripheral gates (no sleep enable, no ram banks), then the ram bank gates of register c
    localparam logic [15:0] PERIPH_A = 16'h3329;
    localparam logic [15:0] PERIPH_B = 16'h97C0;
    localparam logic [15:0] PERIPH_C = 16'hFC00;
    localparam logic [15:0] RAM_BANKS_C = 16'h001F;

    // reset values
    localparam logic [2:0] RST_CORE_RATIO = 3'h0;
    localparam logic [2:0] RST_PERI_RATIO = 3'h1;
    localparam logic [2:0] RST_BUS_RATIO = 3'h0;
    localparam logic [15:0] RST_GATE_A = 16'h3329;
    localparam logic [15:0] RST_GATE_B = 16'h97C0;
    localparam logic [15:0] RST_GATE_C = 16'hFC00;

    // mode pin patterns and their select encodings
    localparam logic [2:0] PINS_MODE2 = 3'h2;
    localparam logic [2:0] PINS_MODE4 = 3'h4;
    localparam logic [2:0] PINS_MODE5 = 3'h5;
    localparam logic [2:0] PINS_MODE6 = 3'h6;
    localparam logic [2:0] PINS_MODE7 = 3'h7;
    localparam logic [3:0] SEL_MODE2 = 4'hC;
    localparam logic [3:0] SEL_MODE4 = 4'h2;
    localparam logic [3:0] SEL_MODE5 = 4'h1;
    localparam logic [3:0] SEL_MODE6 = 4'h5;
    localparam logic [3:0] SEL_MODE7 = 4'h4;
    localparam logic [3:0] SEL_NONE = 4'h0;

    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef struct packed {
        logic [2:0] core;
        logic [2:0] peri;
        logic [2:0] bus;
    } smcms_ratio_type;

    typedef struct packed {
        logic [15:0] a;
        logic [15:0] b;
        logic [15:0] c;
    } smcms_gate_type;

endpackage

//--- smcms_top.sv
// The AXI4-Lite slave port was left to the implementer.
`timescale 1ns/10ps
module smcms_top
    import smcms_pkg::*;
(
    // clock and reset
    input wire logic sys_clk,
    input wire logic rstn,
    // axi4-lite write address
    input wire logic [31:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    // axi4-lite write data
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    // axi4-lite write response
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // axi4-lite read address
    input wire logic [31:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    // axi4-lite read data
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // mode pins
    input wire logic mode_pin_high,
    input wire logic mode_pin_two,
    input wire logic mode_pin_one,
    input wire logic mode_pin_zero,
    // sleep request from the core, same clock
    input wire logic sleep_active,
    // clock control
    output smcms_ratio_type clock_ratio,
    output logic core_clk_en,
    output logic peri_clk_en,
    output logic bus_clk_en,
    // module stop
    output smcms_gate_type module_gate,
    output logic all_clock_stop
);

    // pin synchronisers
    logic [3:0] pins_meta_q;
    logic [3:0] pins_sync_q;

    // mode latch
    logic mode_latched_q;
    logic top_mode_pin_latch_q;
    logic [3:0] mode_select_q;

    // registers
    smcms_ratio_type ratio_q;
    smcms_gate_type gate_q;

    // bus state
    logic awready_q;
    logic wready_q;
    logic aw_held_q;
    logic w_held_q;
    logic [31:0] awaddr_q;
    logic [31:0] wdata_q;
    logic [3:0] wstrb_q;
    logic bvalid_q;
    logic [1:0] bresp_q;
    logic arready_q;
    logic rvalid_q;
    logic [31:0] rdata_q;
    logic [1:0] rresp_q;

    // clock enables
    logic [DIV_W-1:0] div_cnt_q;
    logic core_en_q;
    logic peri_en_q;
    logic bus_en_q;
    logic all_stop_q;

    // unlisted pin patterns read as zero
    function automatic logic [3:0] mode_encode(input logic [2:0] pins);
        logic [3:0] sel;
        sel = SEL_NONE;
        unique case (pins)
            PINS_MODE2: sel = SEL_MODE2;
            PINS_MODE4: sel = SEL_MODE4;
            PINS_MODE5: sel = SEL_MODE5;
            PINS_MODE6: sel = SEL_MODE6;
            PINS_MODE7: sel = SEL_MODE7;
            default: sel = SEL_NONE;
        endcase
        return sel;
    endfunction

    // registers are 16 bits wide; lanes 2 and 3 carry nothing
    function automatic logic [15:0] merge(
        input logic [15:0] old,
        input logic [31:0] data,
        input logic [3:0] strb,
        input logic [15:0] mask
    );
        logic [15:0] nv;
        nv = old;
        if (strb[0]) begin
            nv[7:0] = data[7:0];
        end
        if (strb[1]) begin
            nv[15:8] = data[15:8];
        end
        return nv & mask;
    endfunction

    // ones in the bits the divider must clear for a given ratio code
    function automatic logic [DIV_W-1:0] div_mask(input logic [2:0] code);
        logic [DIV_W:0] t;
        t = {{DIV_W{1'b0}}, 1'b1} << code;
        return DIV_W'(t - {{DIV_W{1'b0}}, 1'b1});
    endfunction

    // write decode
    wire aw_take = s_axi_awvalid && awready_q;
    wire w_take = s_axi_wvalid && wready_q;
    wire do_write = aw_held_q && w_held_q && !bvalid_q;
    wire wr_mode = awaddr_q == ADDR_BOOT_MODE;
    wire wr_clk = awaddr_q == ADDR_CLK_DIV;
    wire wr_ga = awaddr_q == ADDR_GATE_A;
    wire wr_gb = awaddr_q == ADDR_GATE_B;
    wire wr_gc = awaddr_q == ADDR_GATE_C;
    wire wr_hit = wr_mode || wr_clk || wr_ga || wr_gb || wr_gc;
    wire [15:0] clk_word = {5'h00, ratio_q.core, 1'b0, ratio_q.peri,
        1'b0, ratio_q.bus};
    wire [15:0] clk_new = merge(clk_word, wdata_q, wstrb_q, MASK_CLK_DIV);
    wire [15:0] ga_new = merge(gate_q.a, wdata_q, wstrb_q, MASK_GATE_A);
    wire [15:0] gb_new = merge(gate_q.b, wdata_q, wstrb_q, MASK_GATE_B);
    wire [15:0] gc_new = merge(gate_q.c, wdata_q, wstrb_q, MASK_GATE_C);

    // read decode
    wire ar_take = s_axi_arvalid && arready_q;
    wire rd_mode = s_axi_araddr == ADDR_BOOT_MODE;
    wire rd_clk = s_axi_araddr == ADDR_CLK_DIV;
    wire rd_ga = s_axi_araddr == ADDR_GATE_A;
    wire rd_gb = s_axi_araddr == ADDR_GATE_B;
    wire rd_gc = s_axi_araddr == ADDR_GATE_C;
    wire rd_hit = rd_mode || rd_clk || rd_ga || rd_gb || rd_gc;
    wire mode_catch = ar_take && rd_mode && !mode_latched_q;
    // a first read returns the live pins and freezes them in the same cycle
    wire top_live = mode_latched_q ? top_mode_pin_latch_q : pins_sync_q[3];
    wire [3:0] sel_live = mode_latched_q ? mode_select_q : mode_encode(pins_sync_q[2:0]);
    wire [15:0] mode_word = (16'(top_live) << MODE_TOP_BIT)
        | (16'(sel_live) << MODE_SEL_LSB);
    // unmapped reads give zero and an error response
    wire [15:0] rd_word = rd_mode ? mode_word
        : rd_clk ? clk_word
        : rd_ga ? gate_q.a
        : rd_gb ? gate_q.b
        : rd_gc ? gate_q.c
        : 16'h0000;

    // named gates feeding the sleep stop
    // ram banks are left out: they never hold off the deep stop
    wire all_clock_stop_enable = gate_q.a[ALL_STOP_EN_BIT];
    wire periph_all_stopped = ((gate_q.a & PERIPH_A) == PERIPH_A)
        && ((gate_q.b & PERIPH_B) == PERIPH_B)
        && ((gate_q.c & PERIPH_C) == PERIPH_C);
    wire all_stop_d = sleep_active && all_clock_stop_enable && periph_all_stopped;

    // clock enable decode
    // every code is legal, a slower one just halves the rate again
    wire core_en_d = (div_cnt_q & div_mask(ratio_q.core)) == {DIV_W{1'b0}};
    wire peri_en_d = (div_cnt_q & div_mask(ratio_q.peri)) == {DIV_W{1'b0}};
    wire bus_en_d = (div_cnt_q & div_mask(ratio_q.bus)) == {DIV_W{1'b0}};

    // mode pins arrive asynchronously
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            pins_meta_q <= 4'h0;
            pins_sync_q <= 4'h0;
        end else begin
            pins_meta_q <= {mode_pin_high, mode_pin_two, mode_pin_one, mode_pin_zero};
            pins_sync_q <= pins_meta_q;
        end
    end

    // latch is freed only by reset
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            mode_latched_q <= 1'b0;
            top_mode_pin_latch_q <= 1'b0;
            mode_select_q <= SEL_NONE;
        end else if (mode_catch) begin
            mode_latched_q <= 1'b1;
            top_mode_pin_latch_q <= pins_sync_q[3];
            mode_select_q <= mode_encode(pins_sync_q[2:0]);
        end
    end

    // write channel capture, either order
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            awready_q <= 1'b1;
            aw_held_q <= 1'b0;
            awaddr_q <= 32'h00000000;
        end else if (aw_take) begin
            awready_q <= 1'b0;
            aw_held_q <= 1'b1;
            awaddr_q <= s_axi_awaddr;
        end else if (do_write) begin
            awready_q <= 1'b1;
            aw_held_q <= 1'b0;
        end
    end

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            wready_q <= 1'b1;
            w_held_q <= 1'b0;
            wdata_q <= 32'h00000000;
            wstrb_q <= 4'h0;
        end else if (w_take) begin
            wready_q <= 1'b0;
            w_held_q <= 1'b1;
            wdata_q <= s_axi_wdata;
            wstrb_q <= s_axi_wstrb;
        end else if (do_write) begin
            wready_q <= 1'b1;
            w_held_q <= 1'b0;
        end
    end

    // a finished write waits here until its answer is claimed
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            bvalid_q <= 1'b0;
            bresp_q <= RESP_OKAY;
        end else if (do_write) begin
            bvalid_q <= 1'b1;
            bresp_q <= wr_hit ? RESP_OKAY : RESP_SLVERR;
        end else if (s_axi_bready) begin
            bvalid_q <= 1'b0;
        end
    end

    // mode register has no write path
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            ratio_q.core <= RST_CORE_RATIO;
            ratio_q.peri <= RST_PERI_RATIO;
            ratio_q.bus <= RST_BUS_RATIO;
        end else if (do_write && wr_clk) begin
            ratio_q.core <= clk_new[CORE_LSB +: RATIO_W];
            ratio_q.peri <= clk_new[PERI_LSB +: RATIO_W];
            ratio_q.bus <= clk_new[BUS_LSB +: RATIO_W];
        end
    end

    // reset leaves the peripherals stopped and the ram banks running
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            gate_q.a <= RST_GATE_A;
            gate_q.b <= RST_GATE_B;
            gate_q.c <= RST_GATE_C;
        end else if (do_write) begin
            if (wr_ga) begin
                gate_q.a <= ga_new;
            end
            if (wr_gb) begin
                gate_q.b <= gb_new;
            end
            if (wr_gc) begin
                gate_q.c <= gc_new;
            end
        end
    end

    // read channel, one outstanding read
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            arready_q <= 1'b1;
            rvalid_q <= 1'b0;
            rdata_q <= 32'h00000000;
            rresp_q <= RESP_OKAY;
        end else if (ar_take) begin
            arready_q <= 1'b0;
            rvalid_q <= 1'b1;
            rdata_q <= {16'h0000, rd_word};
            rresp_q <= rd_hit ? RESP_OKAY : RESP_SLVERR;
        end else if (rvalid_q && s_axi_rready) begin
            arready_q <= 1'b1;
            rvalid_q <= 1'b0;
        end
    end

    // free-running divider; enables are phase aligned to its wrap
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            div_cnt_q <= {DIV_W{1'b0}};
            core_en_q <= 1'b0;
            peri_en_q <= 1'b0;
            bus_en_q <= 1'b0;
            all_stop_q <= 1'b0;
        end else begin
            div_cnt_q <= div_cnt_q + {{(DIV_W-1){1'b0}}, 1'b1};
            core_en_q <= core_en_d;
            peri_en_q <= peri_en_d;
            bus_en_q <= bus_en_d;
            all_stop_q <= all_stop_d;
        end
    end

    assign s_axi_awready = awready_q;
    assign s_axi_wready = wready_q;
    assign s_axi_bvalid = bvalid_q;
    assign s_axi_bresp = bresp_q;
    assign s_axi_arready = arready_q;
    assign s_axi_rvalid = rvalid_q;
    assign s_axi_rdata = rdata_q;
    assign s_axi_rresp = rresp_q;
    assign clock_ratio = ratio_q;
    assign core_clk_en = core_en_q;
    assign peri_clk_en = peri_en_q;
    assign bus_clk_en = bus_en_q;
    assign module_gate = gate_q;
    assign all_clock_stop = all_stop_q;

endmodule

//--- tb_smcms_top.sv
`timescale 1ns/10ps
module tb_smcms_top
    import smcms_pkg::*;
;
    logic sys_clk = 1'b0;
    logic rstn = 1'b0;
    logic [31:0] s_axi_awaddr = 32'h0, s_axi_wdata = 32'h0, s_axi_araddr = 32'h0;
    logic [3:0] s_axi_wstrb = 4'h0;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, sleep_active = 1'b0;
    logic mode_pin_high = 1'b0, mode_pin_two = 1'b0, mode_pin_one = 1'b0, mode_pin_zero = 1'b0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic [31:0] s_axi_rdata;
    logic core_clk_en, peri_clk_en, bus_clk_en, all_clock_stop;
    smcms_ratio_type clock_ratio;
    smcms_gate_type module_gate;
    int failures = 0;
    int n_tests = 0;
    int cycles = 0;

    smcms_top smcms_top_inst (
        .sys_clk(sys_clk), .rstn(rstn), .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
        .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
        .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
        .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
        .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
        .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
        .mode_pin_high(mode_pin_high), .mode_pin_two(mode_pin_two), .mode_pin_one(mode_pin_one),
        .mode_pin_zero(mode_pin_zero), .sleep_active(sleep_active), .clock_ratio(clock_ratio),
        .core_clk_en(core_clk_en), .peri_clk_en(peri_clk_en), .bus_clk_en(bus_clk_en),
        .module_gate(module_gate), .all_clock_stop(all_clock_stop)
    );

    always #25 sys_clk = ~sys_clk;

    task automatic report_and_stop;
        $display("failures=%0d n_tests=%0d", failures, n_tests);
        if (failures == 0 && n_tests > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    // a hang shows up here instead of running forever
    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 5000) begin
            failures++;
            report_and_stop;
        end
    end

    task automatic check_word(input logic [47:0] got, input logic [47:0] exp);
        n_tests++;
        if (got !== exp) begin
            failures++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic do_reset;
        rstn <= 1'b0;
        repeat (2) @(posedge sys_clk);
        rstn <= 1'b1;
        @(posedge sys_clk);
    endtask

    // address and data offered together, each dropped at its own take
    task automatic wr(input logic [31:0] a, input logic [31:0] d, input logic [3:0] s,
                      input logic [1:0] er);
        logic aw_done;
        logic w_done;
        aw_done = 1'b0;
        w_done = 1'b0;
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_wstrb <= s;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        while (!(aw_done && w_done)) begin
            @(posedge sys_clk);
            if (!aw_done && s_axi_awready === 1'b1) begin
                aw_done = 1'b1;
                s_axi_awvalid <= 1'b0;
            end
            if (!w_done && s_axi_wready === 1'b1) begin
                w_done = 1'b1;
                s_axi_wvalid <= 1'b0;
            end
        end
        do @(posedge sys_clk); while (s_axi_bvalid !== 1'b1);
        check_word({46'h0, s_axi_bresp}, {46'h0, er});
        s_axi_bready <= 1'b0;
        @(posedge sys_clk);
    endtask

    task automatic rd(input logic [31:0] a, input logic [31:0] ed, input logic [1:0] er);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do @(posedge sys_clk); while (s_axi_arready !== 1'b1);
        s_axi_arvalid <= 1'b0;
        do @(posedge sys_clk); while (s_axi_rvalid !== 1'b1);
        check_word({16'h0, s_axi_rdata}, {16'h0, ed});
        check_word({46'h0, s_axi_rresp}, {46'h0, er});
        s_axi_rready <= 1'b0;
        @(posedge sys_clk);
    endtask

    task automatic t_reset_vals;
        rd(ADDR_CLK_DIV, {21'h0, RST_CORE_RATIO, 1'b0, RST_PERI_RATIO, 1'b0, RST_BUS_RATIO},
           RESP_OKAY);
        check_word({39'h0, clock_ratio}, {39'h0, RST_CORE_RATIO, RST_PERI_RATIO, RST_BUS_RATIO});
        check_word(module_gate, {RST_GATE_A, RST_GATE_B, RST_GATE_C});
    endtask

    task automatic t_gates;
        logic [31:0] ga [3] = '{ADDR_GATE_A, ADDR_GATE_B, ADDR_GATE_C};
        logic [15:0] gm [3] = '{MASK_GATE_A, MASK_GATE_B, MASK_GATE_C};
        for (int i = 0; i < 3; i++) begin
            wr(ga[i], 32'hFFFFFFFF, 4'hF, RESP_OKAY);
            rd(ga[i], {16'h0, gm[i]}, RESP_OKAY);
        end
        check_word(module_gate, {MASK_GATE_A, MASK_GATE_B, MASK_GATE_C});
        for (int i = 0; i < 3; i++) begin
            wr(ga[i], 32'h0, 4'hF, RESP_OKAY);
            rd(ga[i], 32'h0, RESP_OKAY);
        end
        check_word(module_gate, 48'h0);
        wr(ADDR_GATE_B, 32'hFFFFFFFF, 4'h2, RESP_OKAY);
        rd(ADDR_GATE_B, {16'h0, MASK_GATE_B & 16'hFF00}, RESP_OKAY);
    endtask

    task automatic t_clock;
        logic [15:0] cfg [2] = '{16'h0321, 16'h0010};
        int exp_n [2][3] = '{'{1, 2, 4}, '{8, 4, 8}};
        int n [3];
        wr(ADDR_CLK_DIV, 32'hFFFFFFFF, 4'hF, RESP_OKAY);
        rd(ADDR_CLK_DIV, {16'h0, MASK_CLK_DIV}, RESP_OKAY);
        check_word({39'h0, clock_ratio}, 48'h1FF);
        for (int k = 0; k < 2; k++) begin
            wr(ADDR_CLK_DIV, {16'h0, cfg[k]}, 4'hF, RESP_OKAY);
            n = '{0, 0, 0};
            repeat (8) begin
                @(posedge sys_clk);
                n[0] += int'(core_clk_en === 1'b1);
                n[1] += int'(peri_clk_en === 1'b1);
                n[2] += int'(bus_clk_en === 1'b1);
            end
            check_word(48'(n[0]), 48'(exp_n[k][0]));
            check_word(48'(n[1]), 48'(exp_n[k][1]));
            check_word(48'(n[2]), 48'(exp_n[k][2]));
        end
    endtask

    task automatic t_sleep;
        wr(ADDR_GATE_A, {16'h0, MASK_GATE_A}, 4'hF, RESP_OKAY);
        wr(ADDR_GATE_B, {16'h0, PERIPH_B}, 4'hF, RESP_OKAY);
        wr(ADDR_GATE_C, {16'h0, PERIPH_C}, 4'hF, RESP_OKAY);
        sleep_active <= 1'b1;
        repeat (2) @(posedge sys_clk);
        check_word({47'h0, all_clock_stop}, 48'h1);
        wr(ADDR_GATE_C, {16'h0, PERIPH_C & 16'h7FFF}, 4'hF, RESP_OKAY);
        check_word({47'h0, all_clock_stop}, 48'h0);
        wr(ADDR_GATE_C, {16'h0, PERIPH_C}, 4'hF, RESP_OKAY);
        wr(ADDR_GATE_A, {16'h0, PERIPH_A}, 4'hF, RESP_OKAY);
        check_word({47'h0, all_clock_stop}, 48'h0);
        sleep_active <= 1'b0;
    endtask

    task automatic t_unmapped;
        rd(ADDR_GATE_A + 32'h4, 32'h0, RESP_SLVERR);
        wr(32'h00000010, 32'hFFFFFFFF, 4'hF, RESP_SLVERR);
    endtask

    // the five listed pin patterns and 000, each after its own reset since the latch holds
    task automatic t_mode;
        logic [2:0] pins [6] = '{PINS_MODE2, PINS_MODE4, PINS_MODE5, PINS_MODE6, PINS_MODE7, 3'h0};
        logic [3:0] sels [6] = '{SEL_MODE2, SEL_MODE4, SEL_MODE5, SEL_MODE6, SEL_MODE7, SEL_NONE};
        logic [31:0] exp_v;
        for (int i = 0; i < 6; i++) begin
            exp_v = {16'h0, i[0], 3'h0, sels[i], 8'h00};
            {mode_pin_two, mode_pin_one, mode_pin_zero} <= pins[i];
            mode_pin_high <= i[0];
            do_reset;
            repeat (2) @(posedge sys_clk);
            rd(ADDR_BOOT_MODE, exp_v, RESP_OKAY);
            {mode_pin_two, mode_pin_one, mode_pin_zero} <= ~pins[i];
            mode_pin_high <= ~i[0];
            repeat (3) @(posedge sys_clk);
            rd(ADDR_BOOT_MODE, exp_v, RESP_OKAY);
            wr(ADDR_BOOT_MODE, 32'h0000FFFF, 4'hF, RESP_OKAY);
            rd(ADDR_BOOT_MODE, exp_v, RESP_OKAY);
        end
    endtask

    initial begin
        do_reset;
        t_reset_vals;
        t_gates;
        t_clock;
        t_sleep;
        t_unmapped;
        t_mode;
        report_and_stop;
    end
endmodule
